// ### inc/vid_pkg.sv
package vid_pkg;
  typedef enum logic [2:0] {STD_601_NTSC, STD_601_PAL, STD_4FSC_NTSC, STD_SQ_NTSC, STD_SQ_PAL} vid_std_t;
  typedef enum logic [1:0] {FMT_SERIAL, FMT_YC16, FMT_YCBCR8, FMT_RGB24} vid_fmt_t;
  // Register offsets
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] OFFSET_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;
  // Control field positions
  localparam int CTRL_STD_LSB   = 0;
  localparam int CTRL_FMT_LSB   = 3;
  localparam int CTRL_ILACE_BIT = 5;
  localparam int CTRL_GSYNC_BIT = 6;
  localparam int CTRL_RGBLV_BIT = 7;
  localparam int CTRL_SETUP_BIT = 8;
  localparam int CTRL_MS_BIT    = 9;
  localparam logic [15:0] CTRL_RST   = 16'h0020;
  localparam logic [15:0] OFFSET_RST = 16'h0000;
  // Timing in sampling clock cycles and line numbers; blanking and RGB levels; serial word counts
  localparam logic [10:0] HCNT_MAX  = 11'h7FF;
  localparam logic [10:0] HS_WIDTH  = 11'h07E;
  localparam logic [9:0]  LINES_NI  = 10'h106;
  localparam logic [9:0]  EQ1_ILACE = 10'h103;
  localparam logic [9:0]  EQ1_NI    = 10'h105;
  localparam logic [9:0]  VS_LAST   = 10'h003;
  localparam logic [9:0]  EQ2_LAST  = 10'h006;
  localparam logic [9:0]  VBL_LAST  = 10'h011;
  localparam logic [7:0]  Y_BLANK   = 8'h10;
  localparam logic [7:0]  C_BLANK   = 8'h80;
  localparam logic [8:0]  RGB_LO_0  = 9'h000;
  localparam logic [8:0]  RGB_HI_0  = 9'h1FE;
  localparam logic [8:0]  RGB_LO_1  = 9'h020;
  localparam logic [8:0]  RGB_HI_1  = 9'h1D6;
  localparam logic [10:0] SER_ACT_WORDS = 11'h5A0;
  localparam logic [10:0] SER_EAV_GUARD = 11'h004;
endpackage : vid_pkg

// ### tb/vid_src_model.sv
`timescale 1ns/10ps
`default_nettype none
module vid_src_model
  import vid_pkg::*;
#(
  parameter int LINE_CLKS   = 1560,
  parameter int FRAME_LINES = 20
) (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        vs_mid_in,
  input  wire logic [10:0] start_in,
  output logic      [23:0] data_out,
  output logic             blank_n_out,
  output logic             hsync_n_out,
  output logic             vsync_n_out,
  output logic      [4:0]  line_out,
  output logic      [10:0] hpos_out
);
  logic [10:0] hpos_reg;
  logic [4:0]  line_reg;
  logic [10:0] vs_pos;
  logic [10:0] phase;
  logic        vs_low;

  // Starts on the last clock of a frame so the first sync edges land after reset
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hpos_reg <= 11'(LINE_CLKS - 1);
      line_reg <= 5'(FRAME_LINES);
    end else if (hpos_reg == 11'(LINE_CLKS - 1)) begin
      hpos_reg <= 11'h000;
      line_reg <= (line_reg == 5'(FRAME_LINES)) ? 5'h01 : line_reg + 5'h01;
    end else begin
      hpos_reg <= hpos_reg + 11'h001;
    end
  end

  assign vs_pos = vs_mid_in ? 11'(LINE_CLKS / 2) : 11'h000;
  assign vs_low = (line_reg >= 5'h01 && line_reg <= 5'h03 && !(line_reg == 5'h01 && hpos_reg < vs_pos))
                  || (line_reg == 5'h04 && hpos_reg < vs_pos);
  assign hsync_n_out = !(hpos_reg < HS_WIDTH);
  assign vsync_n_out = !vs_low;
  // Design counts from the clock after the sync edge, hence the extra one
  assign phase = hpos_reg - start_in - 11'h001;
  assign data_out = {8'h00, phase[0] ? 8'hC0 : 8'h40,
                     phase[1] ? (phase[0] ? 8'h5B : 8'hC0) : (phase[0] ? 8'h5A : 8'h40)};
  // Strobe stays high in blanking too, so the design must discard on its own
  assign blank_n_out = 1'b1;
  assign line_out = line_reg;
  assign hpos_out = hpos_reg;
endmodule : vid_src_model
`default_nettype wire

// ### tb/vid_sync_timing_tb.sv
`timescale 1ns/10ps
`default_nettype none
module vid_sync_timing_tb;
  import vid_pkg::*;
  localparam int LINE_CLKS = 1560;
  localparam int ACT_CLKS  = 1280;
  localparam int REF_SLAVE = 238;
  localparam int TIMEOUT   = 90000;
  localparam logic [15:0] CTRL_BASE = 16'h0033;
  logic        clk;
  logic        rst_n;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic        strap;
  logic        vs_mid;
  logic [10:0] start_pos;
  logic [23:0] vid_data;
  logic        blank_n, hs_n, vs_n;
  logic [4:0]  src_line;
  logic [10:0] src_hpos;
  logic [15:0] rdata;
  logic        hs_out, hs_oe, vs_out, vs_oe, valid, vblank, field_odd, green, setup;
  logic        burst, csync, pclk, pclk_a;
  logic [7:0]  y_out, c_out;
  logic [8:0]  rgb_min, rgb_max;
  logic [15:0] d;
  logic [7:0]  c_first;
  int          err_count, check_count, cyc, first, cnt, bad, n;

  vid_sync_timing i_dut (.CORE_CLK_IN(clk), .ARST_N_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .MASTER_SLAVE_SEL_IN(strap), .VID_DATA_IN(vid_data),
    .BLANK_N_IN(blank_n), .HSYNC_N_IN(hs_n), .HSYNC_N_OUT(hs_out), .HSYNC_OE_OUT(hs_oe), .VSYNC_N_IN(vs_n),
    .VSYNC_N_OUT(vs_out), .VSYNC_OE_OUT(vs_oe), .COMPOSITE_SYNC_N_OUT(csync), .PIXEL_CLK_1X_OUT(pclk),
    .Y_OUT(y_out), .C_OUT(c_out), .PIX_VALID_OUT(valid), .VBLANK_OUT(vblank), .BURST_OFF_OUT(burst),
    .FIELD_ODD_OUT(field_odd),
    .GREEN_SYNC_EN_OUT(green), .SETUP_EN_OUT(setup), .RGB_MIN_OUT(rgb_min), .RGB_MAX_OUT(rgb_max));

  vid_src_model #(.LINE_CLKS(LINE_CLKS), .FRAME_LINES(20)) i_src (.clk_in(clk), .arst_n_in(rst_n),
    .vs_mid_in(vs_mid), .start_in(start_pos), .data_out(vid_data), .blank_n_out(blank_n),
    .hsync_n_out(hs_n), .vsync_n_out(vs_n), .line_out(src_line), .hpos_out(src_hpos));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic end_sim();
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Entered just after a clock edge; strobes last exactly one cycle
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // One idle edge so a following write never re-raises the strobe in the same step
    @(posedge clk);
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] v);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask : reg_rd

  task automatic wait_line(input int l);
    do @(posedge clk); while (!(src_line == 5'(l) && src_hpos == 11'h000));
  endtask : wait_line

  // Edges counted from the one that samples the source's falling line sync
  task automatic measure_line(input int l);
    wait_line(l);
    first = 0;
    cnt = 0;
    bad = 0;
    n = 0;
    repeat (LINE_CLKS) begin
      @(posedge clk);
      n++;
      if (valid === 1'b1) begin
        if (cnt == 0) begin
          first = n;
          c_first = c_out;
        end
        cnt++;
      end else if (y_out !== Y_BLANK || c_out !== C_BLANK) begin
        bad++;
      end
    end
  endtask : measure_line

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == TIMEOUT) begin
      err_count++;
      end_sim();
    end
  end

  initial begin
    {rst_n, addr, wdata, wr, rd, strap, vs_mid, err_count, check_count} = '0;
    start_pos = 11'(REF_SLAVE);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("rdata_idle", rdata, 16'h0000);
    check("luma_reset", 16'(y_out), 16'(Y_BLANK));
    check("chroma_reset", 16'(c_out), 16'(C_BLANK));
    reg_rd(CTRL_OFS, d);
    check("ctrl_reset", d, CTRL_RST);
    reg_rd(4'hC, d);
    check("unmapped_read", d, 16'h0000);
    reg_wr(CTRL_OFS, CTRL_BASE | 16'h00C0);
    repeat (2) @(posedge clk);
    check("green_on", 16'(green), 16'h0001);
    check("rgb_min_1", 16'(rgb_min), 16'(RGB_LO_1));
    check("rgb_max_1", 16'(rgb_max), 16'(RGB_HI_1));
    reg_wr(CTRL_OFS, CTRL_BASE);
    reg_wr(OFFSET_OFS, 16'h0000);
    repeat (2) @(posedge clk);
    check("green_off", 16'(green), 16'h0000);
    check("rgb_min_0", 16'(rgb_min), 16'(RGB_LO_0));
    check("rgb_max_0", 16'(rgb_max), 16'(RGB_HI_0));
    measure_line(5);
    check("vblank_line5", 16'(vblank), 16'h0001);
    check("burst_off_line5", 16'(burst), 16'h0001);
    check("valid_in_vblank", 16'(cnt), 16'h0000);
    check("blank_words", 16'(bad), 16'h0000);
    wait_line(10);
    check("field_odd", 16'(field_odd), 16'h0001);
    wait_line(18);
    reg_wr(CTRL_OFS, CTRL_BASE | 16'h0100);
    repeat (4) @(posedge clk);
    check("setup_held", 16'(setup), 16'h0000);
    measure_line(19);
    check("start_mux8", 16'(first), 16'(REF_SLAVE + 2));
    check("count_mux8", 16'(cnt), 16'(ACT_CLKS));
    check("cb_first_mux8", 16'(c_first), 16'h0040);
    check("blank_words_act", 16'(bad), 16'h0000);
    check("vblank_active", 16'(vblank), 16'h0000);
    check("burst_on_active", 16'(burst), 16'h0000);
    // Same standard in the 16-bit format, with an offset and a mid-line field start
    reg_wr(CTRL_OFS, 16'h012B);
    reg_wr(OFFSET_OFS, 16'h0008);
    vs_mid <= 1'b1;
    start_pos <= 11'(REF_SLAVE - 8);
    wait_line(3);
    check("setup_applied", 16'(setup), 16'h0001);
    wait_line(10);
    check("field_even", 16'(field_odd), 16'h0000);
    reg_rd(STATUS_OFS, d);
    check("status_field", 16'(d[13]), 16'h0000);
    measure_line(19);
    check("start_yc16", 16'(first), 16'(REF_SLAVE - 8 + 2));
    check("count_yc16", 16'(cnt), 16'(ACT_CLKS));
    check("cb_first_yc16", 16'(c_first), 16'h0040);
    strap <= 1'b1;
    repeat (20) @(posedge clk);
    check("hsync_oe", 16'(hs_oe), 16'h0001);
    check("vsync_oe", 16'(vs_oe), 16'h0001);
    pclk_a = pclk;
    @(posedge clk);
    check("pixel_clk_toggle", 16'(pclk), 16'(!pclk_a));
    // Skip any pulse already under way so the width is counted from its start
    do @(posedge clk); while (hs_out !== 1'b1);
    do @(posedge clk); while (hs_out !== 1'b0);
    check("csync_in_hsync", 16'(csync), 16'h0000);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hs_out === 1'b0);
    check("hsync_width", 16'(n), 16'(HS_WIDTH));
    do begin
      @(posedge clk);
      n++;
    end while (hs_out !== 1'b0);
    check("hsync_period", 16'(n), 16'(LINE_CLKS));
    end_sim();
  end
endmodule : vid_sync_timing_tb
`default_nettype wire

// ### verilog/vid_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module vid_pin_sync (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic pin_in,
  output logic      level_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // A change counts only once the later two stages agree
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      level_out <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      level_out <= s3_reg;
    end
  end
endmodule : vid_pin_sync
`default_nettype wire

// ### verilog/vid_sync_timing.sv
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Serial words sampled on rising clock edge
// - Serial valid only while derived blank high
// - Serial pixels after fourth code word, guarded end
// - Parallel data and syncs sampled on rising edge
// - Parallel pixels valid after start delay
// - First valid chroma sample is blue difference
// - Blank strobe honoured only inside active window
// - Master reference delays per standard
// - Slave reference delays per standard
// - Same reference delay for all parallel formats
// - Pin or register selects master or slave
// - Odd field near line start edge
// - Even field near mid-line edge
// - Long lines still give vertical blanking
// - Counter overflow acts as horizontal sync
// - Short lines may lose serrations
// - Field line count stretches first equalizing
// - Control bit adds sync to green
// - Level bit picks RGB output range
// - Register selects NTSC setup pedestal
// - Interlaced equalizing and vertical sync lines
// - Interlaced blanking and burst suppression lines
// - Non-interlaced interval lines
// - Master non-interlaced repeats odd fields only
// - Invalid samples become black and neutral
// - Setup bit takes effect in vertical blanking
module vid_sync_timing
  import vid_pkg::*;
(
  input  wire logic        CORE_CLK_IN,
  input  wire logic        ARST_N_IN,
  input  wire logic [3:0]  REG_ADDR_IN,
  input  wire logic [15:0] REG_WDATA_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic        REG_RD_IN,
  output logic      [15:0] REG_RDATA_OUT,
  input  wire logic        MASTER_SLAVE_SEL_IN,
  input  wire logic [23:0] VID_DATA_IN,
  input  wire logic        BLANK_N_IN,
  input  wire logic        HSYNC_N_IN,
  output logic             HSYNC_N_OUT,
  output logic             HSYNC_OE_OUT,
  input  wire logic        VSYNC_N_IN,
  output logic             VSYNC_N_OUT,
  output logic             VSYNC_OE_OUT,
  output logic             COMPOSITE_SYNC_N_OUT,
  output logic             PIXEL_CLK_1X_OUT,
  output logic      [7:0]  Y_OUT,
  output logic      [7:0]  C_OUT,
  output logic             PIX_VALID_OUT,
  output logic             VBLANK_OUT,
  output logic             BURST_OFF_OUT,
  output logic             FIELD_ODD_OUT,
  output logic             GREEN_SYNC_EN_OUT,
  output logic             SETUP_EN_OUT,
  output logic      [8:0]  RGB_MIN_OUT,
  output logic      [8:0]  RGB_MAX_OUT
);
  function automatic logic [10:0] line_start_ref_delay(vid_std_t s, logic master);
    logic [10:0] d;
    unique case (s)
      STD_601_NTSC:  d = 11'd250;
      STD_601_PAL:   d = 11'd280;
      STD_4FSC_NTSC: d = 11'd266;
      STD_SQ_NTSC:   d = 11'd228;
      STD_SQ_PAL:    d = 11'd306;
      default:       d = 11'd250;
    endcase
    return master ? d : d + 11'd10;
  endfunction : line_start_ref_delay

  function automatic logic [10:0] line_total(vid_std_t s);
    unique case (s)
      STD_601_PAL:   return 11'd1728;
      STD_4FSC_NTSC: return 11'd1820;
      STD_SQ_NTSC:   return 11'd1560;
      STD_SQ_PAL:    return 11'd1888;
      default:       return 11'd1716;
    endcase
  endfunction : line_total

  function automatic logic [10:0] active_len(vid_std_t s);
    unique case (s)
      STD_4FSC_NTSC, STD_SQ_PAL: return 11'd1536;
      STD_SQ_NTSC:               return 11'd1280;
      default:                   return 11'd1440;
    endcase
  endfunction : active_len

  logic [15:0] ctrl_reg;
  logic [15:0] offset_reg;
  logic        ms_pin;
  logic        master;
  vid_std_t    std;
  vid_fmt_t    fmt;
  logic        ilace;
  logic [10:0] total;
  logic [10:0] half;
  logic [10:0] quarter;
  logic [10:0] pixel_start_delay;
  logic [10:0] hcount_reg;
  logic [9:0]  line_reg;
  logic        field_odd_reg;
  logic        hs_d_reg;
  logic        vs_d_reg;
  logic        hs_fall;
  logic        vs_fall;
  logic        line_end;
  logic        ser_blank_h;
  logic        ser_eav;
  logic        eq1;
  logic        in_vblank;
  logic        pix_valid;
  logic        chroma_is_cr_reg;
  logic        ser_is_y_reg;
  logic        started_reg;

  assign std    = vid_std_t'(ctrl_reg[CTRL_STD_LSB +: 3]);
  assign fmt    = vid_fmt_t'(ctrl_reg[CTRL_FMT_LSB +: 2]);
  assign ilace  = ctrl_reg[CTRL_ILACE_BIT];
  assign master = ms_pin | ctrl_reg[CTRL_MS_BIT];
  assign total  = line_total(std);
  assign half   = {1'b0, total[10:1]};
  assign quarter = {2'b00, total[10:2]};
  assign pixel_start_delay = line_start_ref_delay(std, master) - offset_reg[10:0];

  vid_pin_sync u_ms_sync (
    .clk_in    (CORE_CLK_IN),
    .arst_n_in (ARST_N_IN),
    .pin_in    (MASTER_SLAVE_SEL_IN),
    .level_out (ms_pin)
  );

  vid_trs_decode u_trs (
    .clk_in      (CORE_CLK_IN),
    .arst_n_in   (ARST_N_IN),
    .word_in     (VID_DATA_IN[7:0]),
    .blank_h_out (ser_blank_h),
    .eav_out     (ser_eav)
  );

  // Register port
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ctrl_reg   <= CTRL_RST;
      offset_reg <= OFFSET_RST;
    end else if (REG_WR_IN) begin
      if (REG_ADDR_IN == CTRL_OFS) ctrl_reg <= REG_WDATA_IN;
      if (REG_ADDR_IN == OFFSET_OFS) offset_reg <= REG_WDATA_IN;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      REG_RDATA_OUT <= 16'h0000;
    end else if (REG_RD_IN) begin
      unique case (REG_ADDR_IN)
        CTRL_OFS:   REG_RDATA_OUT <= ctrl_reg;
        OFFSET_OFS: REG_RDATA_OUT <= offset_reg;
        STATUS_OFS: REG_RDATA_OUT <= {master, in_vblank, field_odd_reg, 3'b000, line_reg};
        default:    REG_RDATA_OUT <= 16'h0000;
      endcase
    end else begin
      REG_RDATA_OUT <= 16'h0000;
    end
  end

  // Slave edges; syncs are synchronous to the sampling clock
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      hs_d_reg <= 1'b1;
      vs_d_reg <= 1'b1;
    end else begin
      hs_d_reg <= HSYNC_N_IN;
      vs_d_reg <= VSYNC_N_IN;
    end
  end
  assign hs_fall = (fmt == FMT_SERIAL) ? ser_eav : (hs_d_reg && !HSYNC_N_IN);
  assign vs_fall = vs_d_reg && !VSYNC_N_IN;

  // Half-length closing line only in interlaced fields
  assign line_end = master ? ((hcount_reg == total - 11'd1) ||
                              (ilace && line_reg == LINES_NI + 10'd1 && hcount_reg == half - 11'd1))
                           : (hs_fall || hcount_reg == HCNT_MAX);

  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      hcount_reg <= 11'h000;
    end else if (line_end) begin
      hcount_reg <= 11'h000;
    end else begin
      hcount_reg <= hcount_reg + 11'd1;
    end
  end

  // A late vertical edge lets lines run on inside the first equalizing interval
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      line_reg      <= 10'd1;
      field_odd_reg <= 1'b1;
    end else if (!master && vs_fall) begin
      line_reg <= 10'd1;
      if (hcount_reg < quarter || hcount_reg >= total - quarter) begin
        field_odd_reg <= 1'b1;
      end else if (hcount_reg < half + quarter) begin
        field_odd_reg <= 1'b0;
      end
    end else if (line_end) begin
      if (master && line_reg >= (ilace ? LINES_NI + 10'd1 : LINES_NI)) begin
        line_reg      <= 10'd1;
        field_odd_reg <= ilace ? !field_odd_reg : 1'b1;
      end else if (line_reg != 10'h3FF) begin
        line_reg <= line_reg + 10'd1;
      end
    end
  end

  // Vertical intervals; serrations are not rebuilt on short lines
  assign eq1 = ilace ? ((line_reg == EQ1_ILACE && hcount_reg >= half) || line_reg > EQ1_ILACE)
                     : (line_reg >= EQ1_NI);
  assign in_vblank = eq1 || line_reg <= VBL_LAST;

  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      HSYNC_N_OUT          <= 1'b1;
      HSYNC_OE_OUT         <= 1'b0;
      VSYNC_N_OUT          <= 1'b1;
      VSYNC_OE_OUT         <= 1'b0;
      COMPOSITE_SYNC_N_OUT <= 1'b1;
      VBLANK_OUT           <= 1'b1;
      BURST_OFF_OUT        <= 1'b1;
      FIELD_ODD_OUT        <= 1'b1;
      PIXEL_CLK_1X_OUT     <= 1'b0;
    end else begin
      HSYNC_OE_OUT         <= master;
      VSYNC_OE_OUT         <= master;
      HSYNC_N_OUT          <= !(hcount_reg < HS_WIDTH);
      VSYNC_N_OUT          <= !(line_reg <= VS_LAST);
      COMPOSITE_SYNC_N_OUT <= !(hcount_reg < HS_WIDTH || line_reg <= VS_LAST);
      VBLANK_OUT           <= in_vblank;
      BURST_OFF_OUT        <= eq1 || line_reg <= EQ2_LAST;
      FIELD_ODD_OUT        <= field_odd_reg;
      PIXEL_CLK_1X_OUT     <= !PIXEL_CLK_1X_OUT;
    end
  end

  // Output option bits; setup waits for vertical blanking to avoid a mid-picture level step
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      GREEN_SYNC_EN_OUT <= 1'b0;
      SETUP_EN_OUT      <= 1'b0;
      RGB_MIN_OUT       <= RGB_LO_0;
      RGB_MAX_OUT       <= RGB_HI_0;
    end else begin
      GREEN_SYNC_EN_OUT <= ctrl_reg[CTRL_GSYNC_BIT];
      RGB_MIN_OUT       <= ctrl_reg[CTRL_RGBLV_BIT] ? RGB_LO_1 : RGB_LO_0;
      RGB_MAX_OUT       <= ctrl_reg[CTRL_RGBLV_BIT] ? RGB_HI_1 : RGB_HI_0;
      if (in_vblank) begin
        SETUP_EN_OUT <= ctrl_reg[CTRL_SETUP_BIT] && (std != STD_601_PAL) && (std != STD_SQ_PAL);
      end
    end
  end

  // Pixel qualification
  always_comb begin
    if (fmt == FMT_SERIAL) begin
      pix_valid = ser_blank_h;
    end else begin
      pix_valid = BLANK_N_IN && !in_vblank && hcount_reg >= pixel_start_delay &&
                  hcount_reg < pixel_start_delay + active_len(std);
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      chroma_is_cr_reg <= 1'b0;
      ser_is_y_reg     <= 1'b0;
      started_reg      <= 1'b0;
    end else if (!pix_valid) begin
      chroma_is_cr_reg <= 1'b0;
      ser_is_y_reg     <= 1'b0;
      started_reg      <= 1'b0;
    end else begin
      started_reg  <= 1'b1;
      ser_is_y_reg <= !ser_is_y_reg;
      if (fmt == FMT_YC16 || fmt == FMT_RGB24 || ser_is_y_reg) begin
        chroma_is_cr_reg <= started_reg ? !chroma_is_cr_reg : 1'b1;
      end
    end
  end

  // Multiplexed words run Cb Y Cr Y; wide formats carry luma and chroma side by side
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      Y_OUT         <= Y_BLANK;
      C_OUT         <= C_BLANK;
      PIX_VALID_OUT <= 1'b0;
    end else begin
      PIX_VALID_OUT <= pix_valid;
      if (!pix_valid) begin
        Y_OUT <= Y_BLANK;
        C_OUT <= C_BLANK;
      end else if (fmt == FMT_YC16 || fmt == FMT_RGB24) begin
        Y_OUT <= VID_DATA_IN[7:0];
        C_OUT <= VID_DATA_IN[15:8];
      end else if (ser_is_y_reg) begin
        Y_OUT <= VID_DATA_IN[7:0];
      end else begin
        C_OUT <= VID_DATA_IN[7:0];
      end
    end
  end

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);

  a_blank_fill: assert property (!pix_valid |=> Y_OUT == 8'h10 && C_OUT == 8'h80)
    else $error("blank samples not replaced");
  a_start_gate: assert property (pix_valid && fmt != FMT_SERIAL |-> hcount_reg >= pixel_start_delay)
    else $error("pixel before start delay");
  a_vblank_drop: assert property (in_vblank && fmt != FMT_SERIAL |=> !PIX_VALID_OUT)
    else $error("pixel accepted in blanking");
  a_master_drive: assert property (master ##1 master |-> HSYNC_OE_OUT && VSYNC_OE_OUT)
    else $error("master not driving syncs");
  a_odd_judge: assert property (!master && vs_fall && hcount_reg < quarter |=> field_odd_reg)
    else $error("odd field misjudged");
  a_even_judge: assert property (!master && vs_fall && hcount_reg >= quarter &&
                                 hcount_reg < half + quarter |=> !field_odd_reg)
    else $error("even field misjudged");
  a_wrap_line: assert property (!master && hcount_reg == HCNT_MAX && line_reg < 10'd100 &&
                                !vs_fall |=> hcount_reg == 11'h000 && line_reg == $past(line_reg) + 10'd1)
    else $error("overflow did not start a line");
  a_setup_vblank: assert property ($changed(SETUP_EN_OUT) |-> $past(in_vblank))
    else $error("setup changed outside blanking");
  a_cb_first: assert property ($rose(pix_valid) |-> !chroma_is_cr_reg)
    else $error("first chroma not blue difference");
  a_ni_odd: assert property (master && !ilace |=> ##1 field_odd_reg)
    else $error("master progressive left odd field");

  c_slave_even: cover property (!master && vs_fall ##1 !field_odd_reg);
  c_pix_run: cover property (pix_valid [*4]);
  c_master_vs: cover property (master && $fell(VSYNC_N_OUT));
endmodule : vid_sync_timing
`default_nettype wire

// ### verilog/vid_trs_decode.sv
`timescale 1ns/10ps
`default_nettype none
module vid_trs_decode
  import vid_pkg::*;
#(
  parameter logic [10:0] ACT_WORDS = SER_ACT_WORDS,
  parameter logic [10:0] EAV_GUARD = SER_EAV_GUARD
) (
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic [7:0] word_in,
  output logic            blank_h_out,
  output logic            eav_out
);
  logic [7:0]  w1_reg;
  logic [7:0]  w2_reg;
  logic [7:0]  w3_reg;
  logic [10:0] act_reg;
  logic        vblank_reg;
  logic        trs;
  assign trs = (w3_reg == 8'hFF) && (w2_reg == 8'h00) && (w1_reg == 8'h00);
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      w1_reg <= 8'h00;
      w2_reg <= 8'h00;
      w3_reg <= 8'h00;
    end else begin
      w1_reg <= word_in;
      w2_reg <= w1_reg;
      w3_reg <= w2_reg;
    end
  end
  // Valid window opens right after the fourth code word and closes a guard before the end code
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      act_reg     <= 11'h000;
      vblank_reg  <= 1'b1;
      blank_h_out <= 1'b0;
      eav_out     <= 1'b0;
    end else begin
      eav_out <= trs && word_in[4];
      if (trs && !word_in[4]) begin
        act_reg     <= ACT_WORDS - EAV_GUARD;
        vblank_reg  <= word_in[5];
        blank_h_out <= !word_in[5];
      end else if (act_reg > 11'h001) begin
        act_reg <= act_reg - 11'h001;
      end else begin
        act_reg     <= 11'h000;
        blank_h_out <= 1'b0;
      end
      if (trs && word_in[4]) begin
        blank_h_out <= 1'b0;
      end
    end
  end
endmodule : vid_trs_decode
`default_nettype wire
